// >>> design/gtl_bus_if.sv
`timescale 1ns/1ps
// Wired-OR bus: each line is low when any party enables its low drive.
// Enables are active low (0 = pulling low); there are no data outputs,
// only an enable per driven line and the resolved level as input.
interface gtl_bus_if;
    // Device end pull-down requests (active low enable)
    logic [7:0] dev_dio_oe_n;
    logic dev_dav_oe_n;
    logic dev_nrfd_oe_n;
    logic dev_ndac_oe_n;
    logic dev_eoi_oe_n;
    logic dev_srq_oe_n;
    // Controller end pull-down requests (active low enable)
    logic [7:0] ctl_dio_oe_n;
    logic ctl_dav_oe_n;
    logic ctl_nrfd_oe_n;
    logic ctl_ndac_oe_n;
    logic ctl_eoi_oe_n;
    logic ctl_atn_oe_n;
    logic ctl_ifc_oe_n;
    logic ctl_ren_oe_n;
    // Resolved line levels, low active, high when released
    logic [7:0] dio_n;
    logic dav_n;
    logic nrfd_n;
    logic ndac_n;
    logic eoi_n;
    logic atn_n;
    logic srq_n;
    logic ifc_n;
    logic ren_n;

    // Wired-OR resolution of the shared lines; ATN, SRQ, IFC and REN have a single driver each
    assign dio_n = dev_dio_oe_n & ctl_dio_oe_n;
    assign dav_n = dev_dav_oe_n & ctl_dav_oe_n;
    assign nrfd_n = dev_nrfd_oe_n & ctl_nrfd_oe_n;
    assign ndac_n = dev_ndac_oe_n & ctl_ndac_oe_n;
    assign eoi_n = dev_eoi_oe_n & ctl_eoi_oe_n;
    assign atn_n = ctl_atn_oe_n;
    assign srq_n = dev_srq_oe_n;
    assign ifc_n = ctl_ifc_oe_n;
    assign ren_n = ctl_ren_oe_n;

    // Device end of the bus
    modport dev (
        output dev_dio_oe_n, dev_dav_oe_n, dev_nrfd_oe_n, dev_ndac_oe_n,
        output dev_eoi_oe_n, dev_srq_oe_n,
        input dio_n, dav_n, nrfd_n, ndac_n, eoi_n, atn_n, srq_n, ifc_n,
        input ren_n
    );
    // Controller end of the bus
    modport ctl (
        output ctl_dio_oe_n, ctl_dav_oe_n, ctl_nrfd_oe_n, ctl_ndac_oe_n,
        output ctl_eoi_oe_n, ctl_atn_oe_n, ctl_ifc_oe_n, ctl_ren_oe_n,
        input dio_n, dav_n, nrfd_n, ndac_n, eoi_n, atn_n, srq_n, ifc_n,
        input ren_n
    );
endinterface

// >>> design/gtl_controller.sv
`timescale 1ns/1ps
// Controller end: sends attention bytes, talks data, listens to one
// byte at a time, drives IFC and REN levels.
module gtl_controller #(
    parameter int SETTLE_CYC = gtl_pkg::SETTLE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus side
    gtl_bus_if.ctl bus,
    // Byte to send: atn marks a command byte
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_atn,
    input wire logic tx_last,
    output logic tx_ready,
    // Listening enable and received bytes
    input wire logic listen_en,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last,
    // Management levels
    input wire logic ifc_req,
    input wire logic ren_req,
    output logic srq_seen
);
    initial
    begin
        if (SETTLE_CYC < 1 || SETTLE_CYC > 15)
            $error("SETTLE_CYC out of range");
    end

    ////////////////////////////////////////////////////////////////////
    // Input registers
    logic [3:0] s1_q, s2_q;
    logic [7:0] d1_q, d2_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_q <= 4'hf;
            s2_q <= 4'hf;
            d1_q <= 8'hff;
            d2_q <= 8'hff;
        end
        else
        begin
            s1_q <= {bus.dav_n, bus.nrfd_n, bus.ndac_n, bus.srq_n};
            s2_q <= s1_q;
            d1_q <= bus.dio_n;
            d2_q <= d1_q;
        end
    end
    assign srq_seen = ~s2_q[0];

    ////////////////////////////////////////////////////////////////////
    // Source handshake
    typedef enum {CS_IDLE, CS_WAIT, CS_SETTLE, CS_VALID} gtl_cs_t;
    gtl_cs_t cs_q;
    logic [7:0] out_q;
    logic atn_q, eoi_q;
    logic [3:0] cnt_q;
    assign tx_ready = cs_q == CS_IDLE && !ifc_req;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cs_q <= CS_IDLE;
            out_q <= 8'h00;
            atn_q <= 1'b0;
            eoi_q <= 1'b0;
            cnt_q <= 4'h0;
        end
        else if (ifc_req)
        begin
            cs_q <= CS_IDLE;
            atn_q <= 1'b0;
        end
        else
        begin
            case (cs_q)
                CS_IDLE:
                    if (tx_valid)
                    begin
                        out_q <= tx_data;
                        atn_q <= tx_atn;
                        eoi_q <= tx_last;
                        cs_q <= CS_WAIT;
                    end
                    else
                        atn_q <= 1'b0;
                CS_WAIT:
                    if (s2_q[2])
                    begin
                        cnt_q <= 4'(SETTLE_CYC);
                        cs_q <= CS_SETTLE;
                    end
                CS_SETTLE:
                    if (cnt_q <= 4'h1)
                        cs_q <= CS_VALID;
                    else
                        cnt_q <= cnt_q - 4'h1;
                CS_VALID:
                    if (s2_q[1])
                        cs_q <= CS_IDLE;
                default:
                    cs_q <= CS_IDLE;
            endcase
        end
    end
    assign bus.ctl_dio_oe_n = cs_q != CS_IDLE ? ~out_q : 8'hff;
    assign bus.ctl_dav_oe_n = cs_q != CS_VALID;
    assign bus.ctl_eoi_oe_n = !(cs_q != CS_IDLE && eoi_q && !atn_q);
    assign bus.ctl_atn_oe_n = !atn_q;
    assign bus.ctl_ifc_oe_n = !ifc_req;
    assign bus.ctl_ren_oe_n = !ren_req;

    ////////////////////////////////////////////////////////////////////
    // Acceptor handshake
    typedef enum {CA_READY, CA_TAKE, CA_WAIT} gtl_ca_t;
    gtl_ca_t ca_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ca_q <= CA_READY;
            rx_data <= 8'h00;
            rx_last <= 1'b0;
        end
        else if (!listen_en)
            ca_q <= CA_READY;
        else
        begin
            case (ca_q)
                CA_READY:
                    if (!s2_q[3])
                    begin
                        rx_data <= ~d2_q;
                        rx_last <= ~bus.eoi_n;
                        ca_q <= CA_TAKE;
                    end
                CA_TAKE:
                    ca_q <= CA_WAIT;
                CA_WAIT:
                    if (s2_q[3])
                        ca_q <= CA_READY;
                default:
                    ca_q <= CA_READY;
            endcase
        end
    end
    assign rx_valid = ca_q == CA_TAKE;
    assign bus.ctl_nrfd_oe_n = !(listen_en && ca_q != CA_READY);
    assign bus.ctl_ndac_oe_n = !(listen_en && ca_q != CA_WAIT);
endmodule

// >>> design/gtl_device.sv
`timescale 1ns/1ps
// How it works
// - Lines only pulled low or released
// - Eight data lines, line one LSB
// - Attention bytes are addresses or commands
// - Data exchange only when addressed
// - Raise service request on error
// - Controller serial polls on service request (gtl_controller only flags it on srq_seen; the bench sends the poll)
// - Release service request when serial polled
// - Fault report command releases service request
// - Interface clear aborts to idle
// - Remote enable line ignored entirely
// - Talker marks last byte with EOI
// - Rest: NDAC low, DAV high
// - No DAV while NRFD low; settle first
// - Listener: NRFD low, capture, release NDAC
// - NDAC held until byte captured
// - Talker drops DAV after NDAC high
// - Listener pulls NDAC on DAV high
module gtl_device #(
    parameter int SETTLE_CYC = gtl_pkg::SETTLE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus side
    gtl_bus_if.dev bus,
    // Own address
    input wire logic [4:0] my_addr,
    // Outgoing bytes from the drive
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    output logic tx_ready,
    // Incoming data bytes to the drive
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last,
    input wire logic rx_ready,
    // Attention bytes seen, for the command decoder
    output logic cmd_valid,
    output logic [7:0] cmd_byte,
    // Drive events
    input wire logic error_evt,
    input wire logic fault_report,
    // Address and status
    output logic is_talker,
    output logic is_listener,
    output logic srq_pending,
    output logic ifc_abort
);
    initial
    begin
        if (SETTLE_CYC < 1 || SETTLE_CYC > 15)
            $error("SETTLE_CYC out of range");
    end

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [12:0] sync1_q; // First stage, read only by second stage
    logic [12:0] sync2_q; // Usable stage
    logic [12:0] raw;
    // ignore REN
    // Remote enable is not even sampled
    assign raw = {bus.dio_n, bus.dav_n, bus.nrfd_n, bus.ndac_n,
                  bus.eoi_n, bus.atn_n};
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_q <= 13'h1fff;
            sync2_q <= 13'h1fff;
        end
        else
        begin
            sync1_q <= raw;
            sync2_q <= sync1_q;
        end
    end
    logic [7:0] dio_s;
    logic dav_s, nrfd_s, ndac_s, eoi_s, atn_s;
    // bit order
    // Active low lines inverted into true bytes, line one is bit zero
    assign dio_s = ~sync2_q[12:5];
    assign dav_s = ~sync2_q[4];
    assign nrfd_s = ~sync2_q[3];
    assign ndac_s = ~sync2_q[2];
    assign eoi_s = ~sync2_q[1];
    assign atn_s = ~sync2_q[0];

    // IFC needs its own pair; it acts outside the byte path
    logic ifc1_q, ifc2_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ifc1_q <= 1'b0;
            ifc2_q <= 1'b0;
        end
        else
        begin
            ifc1_q <= ~bus.ifc_n;
            ifc2_q <= ifc1_q;
        end
    end
    assign ifc_abort = ifc2_q;

    ////////////////////////////////////////////////////////////////////
    // Acceptor handshake: listens in attention and when addressed
    typedef enum {AH_IDLE, AH_READY, AH_TAKE, AH_WAIT_HI} gtl_ah_t;
    gtl_ah_t ah_q;
    logic listen_q, talk_q, spoll_q;
    logic [7:0] cap_q;
    logic cap_atn_q, cap_eoi_q;
    logic ah_active;
    assign ah_active = atn_s | listen_q;
    // Data bytes stall the handshake until the drive takes them
    logic rx_full_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ah_q <= AH_IDLE;
            cap_q <= 8'h00;
            cap_atn_q <= 1'b0;
            cap_eoi_q <= 1'b0;
        end
        else if (ifc2_q || !ah_active)
            ah_q <= AH_IDLE;
        else
        begin
            case (ah_q)
                // Ready once nothing is pending toward the drive
                AH_IDLE:
                    if (!rx_full_q)
                        ah_q <= AH_READY;
                AH_READY:
                    if (dav_s)
                    begin
                        cap_q <= dio_s;
                        cap_atn_q <= atn_s;
                        cap_eoi_q <= eoi_s;
                        ah_q <= AH_TAKE;
                    end
                // One cycle to hand the byte over, NDAC still held
                AH_TAKE:
                    ah_q <= AH_WAIT_HI;
                AH_WAIT_HI:
                    if (!dav_s)
                        ah_q <= AH_IDLE;
                default:
                    ah_q <= AH_IDLE;
            endcase
        end
    end

    assign bus.dev_nrfd_oe_n = !(ah_active && ah_q != AH_READY);
    assign bus.dev_ndac_oe_n = !(ah_active && ah_q != AH_WAIT_HI);

    ////////////////////////////////////////////////////////////////////
    // Attention decoding
    logic take_pulse;
    assign take_pulse = (ah_q == AH_TAKE) && !ifc2_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            listen_q <= 1'b0;
            talk_q <= 1'b0;
            spoll_q <= 1'b0;
        end
        else if (ifc2_q)
        begin
            listen_q <= 1'b0;
            talk_q <= 1'b0;
            spoll_q <= 1'b0;
        end
        else if (take_pulse && cap_atn_q)
        begin
            if (cap_q[6:0] == gtl_pkg::CMD_UNLISTEN[6:0])
                listen_q <= 1'b0;
            else if (cap_q[6:0] == gtl_pkg::CMD_UNTALK[6:0])
                talk_q <= 1'b0;
            else if (cap_q[6:0] == gtl_pkg::CMD_SPOLL_ON[6:0])
                spoll_q <= 1'b1;
            else if (cap_q[6:0] == gtl_pkg::CMD_SPOLL_OFF[6:0])
                spoll_q <= 1'b0;
            else if (cap_q[6:5] == gtl_pkg::GRP_LISTEN
                     && cap_q[4:0] == my_addr)
                listen_q <= 1'b1;
            else if (cap_q[6:5] == gtl_pkg::GRP_TALK)
                // Own talk address selects; any other one untalks us
                talk_q <= (cap_q[4:0] == my_addr);
        end
    end
    assign is_talker = talk_q;
    assign is_listener = listen_q;

    // Every attention byte goes to the command decoder
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_valid <= 1'b0;
            cmd_byte <= 8'h00;
        end
        else
        begin
            cmd_valid <= take_pulse && cap_atn_q;
            if (take_pulse && cap_atn_q)
                cmd_byte <= cap_q;
        end
    end

    // Data byte holding register toward the drive
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_full_q <= 1'b0;
            rx_data <= 8'h00;
            rx_last <= 1'b0;
        end
        else if (take_pulse && !cap_atn_q)
        begin
            rx_full_q <= 1'b1;
            rx_data <= cap_q;
            rx_last <= cap_eoi_q;
        end
        else if (rx_ready)
            rx_full_q <= 1'b0;
    end
    assign rx_valid = rx_full_q;

    ////////////////////////////////////////////////////////////////////
    // Service request
    logic stb_sent;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            srq_pending <= 1'b0;
        else if (error_evt)
            srq_pending <= 1'b1; // Set beats clear
        else if (stb_sent || fault_report)
            srq_pending <= 1'b0;
    end
    assign bus.dev_srq_oe_n = !srq_pending;

    ////////////////////////////////////////////////////////////////////
    // Source handshake: status byte when polled, else drive data
    typedef enum {SH_IDLE, SH_WAIT_RFD, SH_SETTLE, SH_VALID} gtl_sh_t;
    gtl_sh_t sh_q;
    logic [7:0] out_q;
    logic out_eoi_q, out_stb_q;
    logic [3:0] settle_q;
    logic sh_en;
    assign sh_en = talk_q && !atn_s && !ifc2_q;
    assign tx_ready = sh_en && !spoll_q && sh_q == SH_IDLE;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sh_q <= SH_IDLE;
            out_q <= 8'h00;
            out_eoi_q <= 1'b0;
            out_stb_q <= 1'b0;
            settle_q <= 4'h0;
        end
        else if (!sh_en)
            sh_q <= SH_IDLE;
        else
        begin
            case (sh_q)
                SH_IDLE:
                    if (spoll_q)
                    begin
                        out_q <= 8'h00;
                        out_q[gtl_pkg::STB_RQS] <= srq_pending;
                        out_eoi_q <= 1'b0;
                        out_stb_q <= 1'b1;
                        sh_q <= SH_WAIT_RFD;
                    end
                    else if (tx_valid)
                    begin
                        out_q <= tx_data;
                        out_eoi_q <= tx_last;
                        out_stb_q <= 1'b0;
                        sh_q <= SH_WAIT_RFD;
                    end
                SH_WAIT_RFD:
                    if (!nrfd_s && !ndac_s)
                    begin
                        settle_q <= 4'(SETTLE_CYC);
                        sh_q <= SH_SETTLE;
                    end
                    else if (!nrfd_s)
                    begin
                        settle_q <= 4'(SETTLE_CYC);
                        sh_q <= SH_SETTLE;
                    end
                SH_SETTLE:
                    if (settle_q <= 4'h1)
                        sh_q <= SH_VALID;
                    else
                        settle_q <= settle_q - 4'h1;
                SH_VALID:
                    if (!ndac_s)
                        sh_q <= SH_IDLE;
                default:
                    sh_q <= SH_IDLE;
            endcase
        end
    end
    assign stb_sent = sh_en && sh_q == SH_VALID && !ndac_s && out_stb_q;

    // data lines pulled low for ones
    assign bus.dev_dio_oe_n = (sh_en && sh_q != SH_IDLE) ? ~out_q : 8'hff;
    assign bus.dev_dav_oe_n = !(sh_en && sh_q == SH_VALID);
    assign bus.dev_eoi_oe_n = !(sh_en && sh_q != SH_IDLE && out_eoi_q);
endmodule

// >>> design/gtl_pkg.sv
package gtl_pkg;
    // Data bus width in lines
    localparam int DATA_W = 8;
    // Settling time before data valid, in ns
    localparam int SETTLE_NS = 20;
    // Clock period in ns
    localparam int CLK_NS = 4;
    // Settling cycles, least time so rounded up, at least one
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    // Width of the settle counter
    localparam int SETTLE_W = 4;
    // Address field width and position within attention bytes
    localparam int ADDR_W = 5;
    localparam int ADDR_LSB = 0;
    // Attention byte group codes in bits 6:5
    localparam logic [1:0] GRP_CMD = 2'h0;
    localparam logic [1:0] GRP_LISTEN = 2'h1;
    localparam logic [1:0] GRP_TALK = 2'h2;
    localparam logic [1:0] GRP_SECONDARY = 2'h3;
    // Universal and addressed command codes
    localparam logic [7:0] CMD_UNLISTEN = 8'h3f;
    localparam logic [7:0] CMD_UNTALK = 8'h5f;
    localparam logic [7:0] CMD_SPOLL_ON = 8'h18;
    localparam logic [7:0] CMD_SPOLL_OFF = 8'h19;
    // Status byte bit that reports a pending service request
    localparam int STB_RQS = 6;
    // Reset value of the drive address
    localparam logic [4:0] ADDR_RST = 5'h04;
endpackage

// >>> sim/gtl_assertions.sv
`timescale 1ns/1ps
// Watches the shared bus lines and the device pull-down enables
module gtl_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Resolved lines
    input wire logic [7:0] dio_n,
    input wire logic dav_n,
    input wire logic nrfd_n,
    input wire logic ndac_n,
    input wire logic atn_n,
    input wire logic ifc_n,
    // Device enables
    input wire logic [7:0] dev_dio_oe_n,
    input wire logic dev_dav_oe_n,
    input wire logic dev_nrfd_oe_n,
    input wire logic dev_ndac_oe_n,
    input wire logic dev_eoi_oe_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////
    a_dav_needs_rfd: assert property (
        $fell(dav_n) |-> nrfd_n)
        else $error("data valid raised while not ready");
    a_data_settled: assert property (
        $fell(dav_n) |-> $past(dio_n, 4) == dio_n)
        else $error("data valid raised before data settled");
    a_data_held: assert property (
        ifc_n && !dav_n && !ndac_n |=> $stable(dio_n))
        else $error("data changed before acceptance");
    a_dav_waits_ack: assert property (
        ifc_n && !dav_n && !ndac_n |=> !dav_n)
        else $error("data valid dropped before acceptance");
    // Sync stages delay the reaction by at least one edge
    a_rfd_drops: assert property (
        $fell(dav_n) && !dev_ndac_oe_n
        |-> ##1 dev_nrfd_oe_n ##[1:5] !dev_nrfd_oe_n)
        else $error("listener did not drop ready in time");
    a_ndac_late: assert property (
        $rose(ndac_n) && !dav_n |-> !nrfd_n)
        else $error("accepted released out of order");
    a_ndac_rearm: assert property (
        $rose(dav_n) && !$past(nrfd_n) && atn_n |-> ##[1:6] !ndac_n)
        else $error("accepted not pulled low again");
    a_ifc_release: assert property (
        !ifc_n [*4] |-> dev_dav_oe_n && dev_eoi_oe_n && &dev_dio_oe_n)
        else $error("device still talking under clear");
    a_atn_no_talk: assert property (
        !atn_n [*4] |-> dev_dav_oe_n && &dev_dio_oe_n)
        else $error("device drives data during attention");

    // Main scenarios reached
    c_dev_talks: cover property ($fell(dev_dav_oe_n));
    c_dev_listens: cover property ($rose(ndac_n) && !dev_nrfd_oe_n);
    c_clear: cover property ($fell(ifc_n));
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    // Clock, reset and bench state
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;
    // Controller user side
    logic c_tx_valid = 1'b0, c_tx_atn = 1'b0, c_tx_last = 1'b0;
    logic [7:0] c_tx_data = 8'h00;
    logic c_tx_ready, c_rx_valid, c_rx_last, srq_seen;
    logic [7:0] c_rx_data;
    logic listen_en = 1'b0, ifc_req = 1'b0, ren_req = 1'b0;
    // Device user side
    logic d_tx_valid = 1'b0, d_tx_last = 1'b0;
    logic [7:0] d_tx_data = 8'h00;
    logic d_tx_ready, d_rx_valid, d_rx_last, cmd_valid;
    logic [7:0] d_rx_data, cmd_byte;
    logic error_evt = 1'b0, fault_report = 1'b0;
    logic is_talker, is_listener, srq_pending, ifc_abort;
    // Captured results
    logic [7:0] last_cmd, d_got, c_got, dio_seen;
    logic d_lst, c_lst, eoi_seen;

    gtl_bus_if bus ();
    gtl_device i_gtl_device (.clk(clk), .rst_n(rst_n), .bus(bus),
        .my_addr(5'h04), .tx_valid(d_tx_valid), .tx_data(d_tx_data),
        .tx_last(d_tx_last), .tx_ready(d_tx_ready),
        .rx_valid(d_rx_valid), .rx_data(d_rx_data), .rx_last(d_rx_last),
        .rx_ready(1'b1), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
        .error_evt(error_evt), .fault_report(fault_report),
        .is_talker(is_talker), .is_listener(is_listener),
        .srq_pending(srq_pending), .ifc_abort(ifc_abort));
    gtl_controller i_gtl_controller (.clk(clk), .rst_n(rst_n),
        .bus(bus), .tx_valid(c_tx_valid), .tx_data(c_tx_data),
        .tx_atn(c_tx_atn), .tx_last(c_tx_last), .tx_ready(c_tx_ready),
        .listen_en(listen_en), .rx_valid(c_rx_valid),
        .rx_data(c_rx_data), .rx_last(c_rx_last), .ifc_req(ifc_req),
        .ren_req(ren_req), .srq_seen(srq_seen));
    gtl_chk i_gtl_chk (.clk(clk), .rst_n(rst_n), .dio_n(bus.dio_n),
        .dav_n(bus.dav_n), .nrfd_n(bus.nrfd_n), .ndac_n(bus.ndac_n),
        .atn_n(bus.atn_n), .ifc_n(bus.ifc_n),
        .dev_dio_oe_n(bus.dev_dio_oe_n), .dev_dav_oe_n(bus.dev_dav_oe_n),
        .dev_nrfd_oe_n(bus.dev_nrfd_oe_n),
        .dev_ndac_oe_n(bus.dev_ndac_oe_n),
        .dev_eoi_oe_n(bus.dev_eoi_oe_n));

    ////////////////////////////////////////////////////////////////////
    // 250 MHz clock
    initial
    begin
        forever #2 clk = ~clk;
    end

    // Capture on the falling edge, where outputs have settled
    always @(negedge clk)
    begin
        if (cmd_valid === 1'b1)
            last_cmd = cmd_byte;
        if (d_rx_valid === 1'b1)
        begin
            d_got = d_rx_data;
            d_lst = d_rx_last;
        end
        if (c_rx_valid === 1'b1)
        begin
            c_got = c_rx_data;
            c_lst = c_rx_last;
        end
        // Wire levels while data is marked valid
        if (bus.dav_n === 1'b0)
        begin
            dio_seen = bus.dio_n;
            eoi_seen = bus.eoi_n;
        end
    end

    // Hang guard, well above the few hundred cycles needed
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            give_verdict;
        end
    end

    ////////////////////////////////////////////////////////////////////
    task chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %0t byte %h exp %h", $time, g, e);
        end
    endtask

    task chk1(input logic g, input logic e);
        compares++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %0t flag %b exp %b", $time, g, e);
        end
    endtask

    // One full handshake: valid falls, then rises, then settles
    task xfer_done;
        @(negedge clk iff bus.dav_n === 1'b0);
        @(negedge clk iff bus.dav_n === 1'b1);
        repeat (6) @(negedge clk);
    endtask

    task ctl_send(input logic [7:0] b, input logic atn, input logic last);
        @(posedge clk);
        #1;
        c_tx_valid = 1'b1;
        c_tx_data = b;
        c_tx_atn = atn;
        c_tx_last = last;
        @(negedge clk iff c_tx_ready === 1'b1);
        @(posedge clk);
        #1;
        c_tx_valid = 1'b0;
        xfer_done;
    endtask

    task dev_send(input logic [7:0] b, input logic last);
        @(posedge clk);
        #1;
        d_tx_valid = 1'b1;
        d_tx_data = b;
        d_tx_last = last;
        @(negedge clk iff d_tx_ready === 1'b1);
        @(posedge clk);
        #1;
        d_tx_valid = 1'b0;
        xfer_done;
    endtask

    task automatic pulse(ref logic s);
        @(posedge clk);
        #1;
        s = 1'b1;
        @(posedge clk);
        #1;
        s = 1'b0;
        repeat (6) @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////
    // Listen address, two data bytes back to back, last one marked
    task t_listen;
        ctl_send(8'h24, 1'b1, 1'b0);
        chk(last_cmd, 8'h24);
        chk1(is_listener, 1'b1);
        ren_req = 1'b1;
        ctl_send(8'h5a, 1'b0, 1'b0);
        chk(d_got, 8'h5a);
        chk1(d_lst, 1'b0);
        ctl_send(8'ha5, 1'b0, 1'b1);
        chk(d_got, 8'ha5);
        chk(dio_seen, ~8'ha5);
        chk1(eoi_seen, 1'b0);
        chk1(d_lst, 1'b1);
        ren_req = 1'b0;
        repeat (4) @(negedge clk);
        chk1(is_listener, 1'b1);
    endtask

    // Unaddressed device must not take data
    task t_unlisten;
        ctl_send(8'h3f, 1'b1, 1'b0);
        chk1(is_listener, 1'b0);
        d_got = 8'h00;
        ctl_send(8'h11, 1'b0, 1'b0);
        chk(d_got, 8'h00);
    endtask

    // Device talks one final byte to the listening controller
    task t_talk;
        ctl_send(8'h44, 1'b1, 1'b0);
        chk1(is_talker, 1'b1);
        listen_en = 1'b1;
        dev_send(8'h3c, 1'b1);
        chk(c_got, 8'h3c);
        chk(dio_seen, ~8'h3c);
        chk1(c_lst, 1'b1);
        listen_en = 1'b0;
        ctl_send(8'h5f, 1'b1, 1'b0);
        chk1(is_talker, 1'b0);
    endtask

    // Service request raised, then released by report and by poll
    task t_srq;
        pulse(error_evt);
        chk1(srq_pending, 1'b1);
        chk1(bus.srq_n, 1'b0);
        chk1(srq_seen, 1'b1);
        pulse(fault_report);
        chk1(bus.srq_n, 1'b1);
        pulse(error_evt);
        ctl_send(8'h18, 1'b1, 1'b0);
        listen_en = 1'b1;
        ctl_send(8'h44, 1'b1, 1'b0);
        xfer_done;
        chk(c_got, 8'h40);
        chk1(bus.srq_n, 1'b1);
        chk1(srq_pending, 1'b0);
        listen_en = 1'b0;
        ctl_send(8'h19, 1'b1, 1'b0);
        ctl_send(8'h5f, 1'b1, 1'b0);
    endtask

    // Interface clear raises ifc_abort and drops the listener role
    task t_ifc;
        ctl_send(8'h24, 1'b1, 1'b0);
        ifc_req = 1'b1;
        repeat (5) @(negedge clk);
        chk1(ifc_abort, 1'b1);
        chk1(is_listener, 1'b0);
        ifc_req = 1'b0;
    endtask

    task give_verdict;
        if (n_errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_listen;
        t_unlisten;
        t_talk;
        t_srq;
        t_ifc;
        give_verdict;
    end
endmodule
